// File: rtl/peak_current_bridge_pwm.sv
// Purpose: gate drive generation for a peak current controlled bridge
// Assumes: one clock mclk, comparator output is asynchronous
// Notes:   registers reached over AHB-Lite, zero wait state
// Operation
// R1: on peak current, active drive drops at once; partner follows deadtime
// R2: peak reference falls as a ramp with programmable slope
// R3: both halves of a switching cycle use one reference value
// R4: passive pair complementary at half duty with deadband
// R5: active action output goes high on up-count trip and at period
// R6: active action output goes low on down-count trip and at zero
// R7: both trip events come from one comparator event
// R8: rising delay on active A, falling delay with inversion on active B
// R9: active A falls on down trip, active B on up trip, immediately
// R10: trip latch is cycle by cycle, cleared at zero and at period
// R11: rectifier mode 0 keeps both rectifier drives off
// R12: rectifier mode 1 drives on only during diagonal overlap
// R13: rectifier mode 2 drives off only during opposite diagonal overlap
// R14: rectifier mode changes are glitch free
// R15: software writes peak reference into ramp start shadow, used each ramp
// R16: falling ramp feeds the 12-bit reference dac
// R17: dac takes upper 12 ramp bits; low 4 bits prescale the rate
// R18: pairs map to switches one/four, two/three, rectifier one/two
// R19: software should lengthen deadtime as load falls
// R20: diagonal pairs run half duty, half a cycle apart
// R21: all pairs share one up-down time base
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module peak_current_bridge_pwm #(
   parameter int unsigned CW = bridge_pkg::CNT_W
) (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   input  wire logic                cmp_trip_async,
   output bridge_pkg::drive_t       drive,
   output logic [bridge_pkg::DAC_W-1:0] dac_code
);
   import bridge_pkg::*;

   if (CW < 16 || CW > 16) begin : g_chk
      $error("counter width must be 16");
   end

   // bus slave state
   cfg_t        cfg_ff, nxt_cfg;
   logic        wr_pend_ff, nxt_wr_pend;
   logic [7:0]  wr_addr_ff, nxt_wr_addr;
   logic [31:0] rdata_ff, nxt_rdata;

   // time base and trip state
   logic [15:0] cnt_ff, nxt_cnt;
   logic        up_ff, nxt_up;
   logic [15:0] per_act_ff, nxt_per_act;
   logic        trip_ff, nxt_trip;
   logic [1:0]  sync_ff;
   rect_mode_t  mode_act_ff, nxt_mode_act;

   // ramp state
   logic [15:0] ramp_ff, nxt_ramp;
   logic [15:0] start_act_ff, nxt_start_act;
   logic [15:0] slope_act_ff, nxt_slope_act;

   // leg state
   logic        aq_act_ff, nxt_aq_act;
   logic        aq_pas_ff, nxt_aq_pas;
   logic [15:0] dba_ff, nxt_dba;
   logic [15:0] dbp_ff, nxt_dbp;
   drive_t      drv_ff, nxt_drv;

   logic        zero_evt;
   logic        period_match;
   logic        compare_a_event_two;
   logic        trip_event_counting_up;
   logic        trip_event_counting_down;
   logic        trip_a_down_event;
   logic        trip_b_up_event;
   logic        diag_one;
   logic        diag_two;
   logic        addr_ok;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_ff;
   assign drive     = drv_ff;
   assign dac_code  = ramp_ff[15:4]; // R16 R17

   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

   // register file: writes land in the data phase, reads are
   // captured in the address phase so hrdata comes from a flop
   always_comb begin
      nxt_cfg     = cfg_ff;
      nxt_wr_pend = addr_ok && hwrite;
      nxt_wr_addr = haddr[7:0];
      nxt_rdata   = rdata_ff;
      if (wr_pend_ff) begin
         case (wr_addr_ff)
            OFS_CTRL: begin
               nxt_cfg.enable = hwdata[CTRL_EN_BIT];
               nxt_cfg.mode   = rect_mode_t'(hwdata[CTRL_MODE_LSB +: 2]);
            end
            OFS_PERIOD:     nxt_cfg.period     = hwdata[15:0];
            OFS_DB_ACTIVE:  nxt_cfg.db_active  = hwdata[15:0];
            OFS_DB_PASSIVE: nxt_cfg.db_passive = hwdata[15:0];
            OFS_RAMP_START: nxt_cfg.ramp_start = hwdata[15:0]; // R15
            OFS_RAMP_SLOPE: nxt_cfg.ramp_slope = hwdata[15:0]; // R2
            default: ;
         endcase
      end
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            OFS_CTRL: nxt_rdata = {29'h0, cfg_ff.mode, cfg_ff.enable};
            OFS_PERIOD:     nxt_rdata = {16'h0, cfg_ff.period};
            OFS_DB_ACTIVE:  nxt_rdata = {16'h0, cfg_ff.db_active};
            OFS_DB_PASSIVE: nxt_rdata = {16'h0, cfg_ff.db_passive};
            OFS_RAMP_START: nxt_rdata = {16'h0, cfg_ff.ramp_start};
            OFS_RAMP_SLOPE: nxt_rdata = {16'h0, cfg_ff.ramp_slope};
            OFS_STATUS: nxt_rdata = {12'h0, mode_act_ff, trip_ff,
                                     up_ff, cnt_ff};
            OFS_RAMP_VALUE: nxt_rdata = {16'h0, ramp_ff};
            default:        nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg_ff     <= '{enable: 1'b0, mode: RECT_DIODE,
                         period: RST_PERIOD, db_active: RST_DB,
                         db_passive: RST_DB, ramp_start: RST_RAMP_START,
                         ramp_slope: RST_RAMP_SLOPE};
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         rdata_ff   <= 32'h0;
      end else begin
         cfg_ff     <= nxt_cfg;
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
         rdata_ff   <= nxt_rdata;
      end
   end

   // comparator synchroniser; second stage is the only reader of the first
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_ff <= 2'b00;
      end else begin
         sync_ff <= {sync_ff[0], cmp_trip_async};
      end
   end

   // one shared up-down time base for all pairs
   assign zero_evt     = cfg_ff.enable && (cnt_ff == 16'h0000); // R21
   assign period_match = cfg_ff.enable && (cnt_ff == per_act_ff); // R21

   // first high synchronised comparator sample per half cycle is the only trip source
   assign compare_a_event_two = cfg_ff.enable && sync_ff[1] && !trip_ff;
   assign trip_event_counting_up   = compare_a_event_two && up_ff;  // R7
   assign trip_event_counting_down = compare_a_event_two && !up_ff; // R7
   assign trip_a_down_event = trip_event_counting_down; // R9
   assign trip_b_up_event   = trip_event_counting_up;   // R9

   always_comb begin
      nxt_cnt       = cnt_ff;
      nxt_up        = up_ff;
      nxt_per_act   = per_act_ff;
      nxt_start_act = start_act_ff;
      nxt_slope_act = slope_act_ff;
      nxt_mode_act  = mode_act_ff;
      if (!cfg_ff.enable) begin
         nxt_cnt     = 16'h0000;
         nxt_up      = 1'b1;
         nxt_per_act = cfg_ff.period;
      end else if (up_ff) begin
         nxt_cnt = cnt_ff + 16'h0001;
         if (nxt_cnt >= per_act_ff) begin
            nxt_up = 1'b0;
         end
      end else begin
         nxt_cnt = cnt_ff - 16'h0001;
         if (nxt_cnt == 16'h0000) begin
            nxt_up = 1'b1;
         end
      end
      // shadows move only at zero or while disabled, so both halves share one reference
      // and a mode change never splits a drive pulse
      if (zero_evt || !cfg_ff.enable) begin
         nxt_start_act = cfg_ff.ramp_start; // R3 R15
         nxt_slope_act = cfg_ff.ramp_slope; // R2
         nxt_mode_act  = cfg_ff.mode;       // R14
         if (cfg_ff.enable) begin
            nxt_per_act = cfg_ff.period;
         end
      end
   end

   // trip latch: a trip in the clearing cycle still sets it
   always_comb begin
      nxt_trip = trip_ff;
      if (compare_a_event_two) begin
         nxt_trip = 1'b1;
      end else if (zero_evt || period_match || !cfg_ff.enable) begin
         nxt_trip = 1'b0; // R10
      end
   end

   // falling ramp restarts from the same start value each half cycle
   always_comb begin
      nxt_ramp = ramp_ff;
      if (zero_evt || period_match || !cfg_ff.enable) begin
         nxt_ramp = (zero_evt || !cfg_ff.enable) ?
                    cfg_ff.ramp_start : start_act_ff; // R3 R15
      end else if (ramp_ff > slope_act_ff) begin
         nxt_ramp = ramp_ff - slope_act_ff; // R2 R16 R17
      end else begin
         nxt_ramp = 16'h0000;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_ff       <= 16'h0000;
         up_ff        <= 1'b1;
         per_act_ff   <= RST_PERIOD;
         start_act_ff <= RST_RAMP_START;
         slope_act_ff <= RST_RAMP_SLOPE;
         mode_act_ff  <= RECT_DIODE;
         trip_ff      <= 1'b0;
         ramp_ff      <= RST_RAMP_START;
      end else begin
         cnt_ff       <= nxt_cnt;
         up_ff        <= nxt_up;
         per_act_ff   <= nxt_per_act;
         start_act_ff <= nxt_start_act;
         slope_act_ff <= nxt_slope_act;
         mode_act_ff  <= nxt_mode_act;
         trip_ff      <= nxt_trip;
         ramp_ff      <= nxt_ramp;
      end
   end

   // action outputs and deadband timers
   always_comb begin
      nxt_aq_act = aq_act_ff;
      if (trip_event_counting_up || period_match) begin
         nxt_aq_act = 1'b1; // R5
      end else if (trip_event_counting_down || zero_evt) begin
         nxt_aq_act = 1'b0; // R6
      end
      nxt_aq_pas = aq_pas_ff;
      if (zero_evt) begin
         nxt_aq_pas = 1'b1; // R4 R20
      end else if (period_match) begin
         nxt_aq_pas = 1'b0; // R4 R20
      end
      if (!cfg_ff.enable) begin
         nxt_aq_act = 1'b0;
         nxt_aq_pas = 1'b0;
      end
      nxt_dba = (nxt_aq_act != aq_act_ff) ? 16'h0000 :
                (dba_ff == 16'hffff) ? dba_ff : dba_ff + 16'h0001;
      nxt_dbp = (nxt_aq_pas != aq_pas_ff) ? 16'h0000 :
                (dbp_ff == 16'hffff) ? dbp_ff : dbp_ff + 16'h0001;
   end

   // bridge pairs, then rectifier overlap decode on the next values
   always_comb begin
      nxt_drv = '0;
      if (cfg_ff.enable) begin
         // switches one and four, complementary with deadband
         nxt_drv.passive_leg_out_a = nxt_aq_pas &&
                                     (nxt_dbp >= cfg_ff.db_passive); // R4 R18
         nxt_drv.passive_leg_out_b = !nxt_aq_pas &&
                                     (nxt_dbp >= cfg_ff.db_passive); // R4 R18
         // switches two and three; trip edges drop the drive at once
         nxt_drv.active_leg_out_a = nxt_aq_act && !trip_a_down_event &&
                                    (nxt_dba >= cfg_ff.db_active); // R1 R8 R9
         nxt_drv.active_leg_out_b = !nxt_aq_act && !trip_b_up_event &&
                                    (nxt_dba >= cfg_ff.db_active); // R1 R8 R9
      end
      diag_one = nxt_drv.passive_leg_out_a && nxt_drv.active_leg_out_b;
      diag_two = nxt_drv.passive_leg_out_b && nxt_drv.active_leg_out_a;
      // mode is only the latched copy, so a register write mid cycle
      // cannot chop a rectifier pulse
      case (mode_act_ff)
         RECT_DIODE: begin
            nxt_drv.rectifier_out_a = 1'b0; // R11
            nxt_drv.rectifier_out_b = 1'b0; // R11
         end
         RECT_IDEAL: begin
            nxt_drv.rectifier_out_a = diag_one; // R12 R18
            nxt_drv.rectifier_out_b = diag_two; // R12 R18
         end
         RECT_COMPLEMENT: begin
            nxt_drv.rectifier_out_a = cfg_ff.enable && !diag_two; // R13
            nxt_drv.rectifier_out_b = cfg_ff.enable && !diag_one; // R13
         end
         default: begin
            nxt_drv.rectifier_out_a = 1'b0;
            nxt_drv.rectifier_out_b = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aq_act_ff <= 1'b0;
         aq_pas_ff <= 1'b0;
         dba_ff    <= 16'h0000;
         dbp_ff    <= 16'h0000;
         drv_ff    <= '0;
      end else begin
         aq_act_ff <= nxt_aq_act;
         aq_pas_ff <= nxt_aq_pas;
         dba_ff    <= nxt_dba;
         dbp_ff    <= nxt_dbp;
         drv_ff    <= nxt_drv;
      end
   end

   AST_TRIP_DROPS_A: assert property (@(posedge mclk) disable iff (rst) // R1
      trip_a_down_event |=> !drive.active_leg_out_a)
      else $error("active A still high after down trip");
   AST_TRIP_DROPS_B: assert property (@(posedge mclk) disable iff (rst) // R9
      trip_b_up_event |=> !drive.active_leg_out_b)
      else $error("active B still high after up trip");
   AST_RAMP_FALLS: assert property (@(posedge mclk) disable iff (rst) // R2
      (cfg_ff.enable && !zero_evt && !period_match)
      |=> ramp_ff <= $past(ramp_ff))
      else $error("ramp rose inside a half cycle");
   AST_SAME_REF: assert property (@(posedge mclk) disable iff (rst) // R3
      period_match |=> ramp_ff == $past(start_act_ff))
      else $error("second half used another reference");
   AST_PASSIVE_COMPL: assert property (@(posedge mclk) disable iff (rst) // R4
      !(drive.passive_leg_out_a && drive.passive_leg_out_b))
      else $error("passive pair overlap");
   AST_AQ_SET: assert property (@(posedge mclk) disable iff (rst) // R5
      (trip_event_counting_up || period_match) |=> aq_act_ff)
      else $error("action output not set");
   AST_AQ_CLR: assert property (@(posedge mclk) disable iff (rst) // R6
      (zero_evt && !trip_event_counting_up) |=> !aq_act_ff)
      else $error("action output not cleared at zero");
   AST_ACTIVE_DB: assert property (@(posedge mclk) disable iff (rst) // R8
      (drive.active_leg_out_a || drive.active_leg_out_b)
      |-> dba_ff >= $past(cfg_ff.db_active))
      else $error("active drive rose inside its deadtime");
   AST_TRIP_CLEAR: assert property (@(posedge mclk) disable iff (rst) // R10
      ((zero_evt || period_match) && !compare_a_event_two)
      |=> !trip_ff)
      else $error("trip latch not cleared");
   AST_MODE0_OFF: assert property (@(posedge mclk) disable iff (rst) // R11
      (mode_act_ff == RECT_DIODE)
      |=> (!drive.rectifier_out_a && !drive.rectifier_out_b))
      else $error("rectifier driven in diode mode");
   AST_IDEAL_DIAG: assert property (@(posedge mclk) disable iff (rst) // R12
      (mode_act_ff == RECT_IDEAL) |=>
      (drive.rectifier_out_a ==
       (drive.passive_leg_out_a && drive.active_leg_out_b)) &&
      (drive.rectifier_out_b ==
       (drive.passive_leg_out_b && drive.active_leg_out_a)))
      else $error("ideal diode rectifier off its diagonal");
   AST_MODE_AT_ZERO: assert property (@(posedge mclk) disable iff (rst) // R14
      (mode_act_ff != $past(mode_act_ff)) |-> $past(zero_evt)
      || $past(!cfg_ff.enable))
      else $error("rectifier mode moved mid cycle");
   // a decrement of sixteen must move the dac code by exactly one step
   AST_DAC_BITS: assert property (@(posedge mclk) disable iff (rst) // R17
      (cfg_ff.enable && !zero_evt && !period_match &&
       slope_act_ff == 16'h0010)
      |=> (dac_code == $past(dac_code) - 12'h001) || (dac_code == 12'h000))
      else $error("dac code not from upper ramp bits");

endmodule

// File: rtl/bridge_pkg.sv
// Purpose: shared constants and carriers of the bridge pwm block
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes:   offsets are byte addresses
package bridge_pkg;

   localparam int unsigned CNT_W = 16;
   localparam int unsigned DAC_W = 12;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_PERIOD     = 8'h04;
   localparam logic [7:0] OFS_DB_ACTIVE  = 8'h08;
   localparam logic [7:0] OFS_DB_PASSIVE = 8'h0c;
   localparam logic [7:0] OFS_RAMP_START = 8'h10;
   localparam logic [7:0] OFS_RAMP_SLOPE = 8'h14;
   localparam logic [7:0] OFS_STATUS     = 8'h18;
   localparam logic [7:0] OFS_RAMP_VALUE = 8'h1c;

   // control field positions
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;

   // status field positions
   localparam int unsigned STS_DIR_BIT   = 16;
   localparam int unsigned STS_TRIP_BIT  = 17;
   localparam int unsigned STS_MODE_LSB  = 18;

   // values after reset
   localparam logic [15:0] RST_PERIOD     = 16'h01f4;
   localparam logic [15:0] RST_DB         = 16'h0000;
   localparam logic [15:0] RST_RAMP_START = 16'h0000;
   localparam logic [15:0] RST_RAMP_SLOPE = 16'h0000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   typedef enum logic [1:0] {
      RECT_DIODE,
      RECT_IDEAL,
      RECT_COMPLEMENT
   } rect_mode_t;

   typedef struct packed {
      logic        enable;
      rect_mode_t  mode;
      logic [15:0] period;
      logic [15:0] db_active;
      logic [15:0] db_passive;
      logic [15:0] ramp_start;
      logic [15:0] ramp_slope;
   } cfg_t;

   typedef struct packed {
      logic passive_leg_out_a;
      logic passive_leg_out_b;
      logic active_leg_out_a;
      logic active_leg_out_b;
      logic rectifier_out_a;
      logic rectifier_out_b;
   } drive_t;

endpackage

// File: dv/gate_driver_model.sv
// Purpose: stand-in for the gate drivers of bridge and rectifier switches
// Assumes: active high gate commands, one per switch
// Notes:   latches any leg overlap, which would short the supply bus
`timescale 1ns/10ps
module gate_driver_model (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire bridge_pkg::drive_t drive,
   output logic                    shoot_ff
);
   import bridge_pkg::*;
   logic nxt_shoot;
   // a real driver pair would conduct through both switches of a leg
   always_comb begin
      nxt_shoot = shoot_ff;
      if (drive.passive_leg_out_a && drive.passive_leg_out_b) begin
         nxt_shoot = 1'b1;
      end
      if (drive.active_leg_out_a && drive.active_leg_out_b) begin
         nxt_shoot = 1'b1;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shoot_ff <= 1'b0;
      end else begin
         shoot_ff <= nxt_shoot;
      end
   end
endmodule

// File: dv/peak_current_bridge_pwm_tb_top.sv
// Purpose: self-checking bench of the bridge pwm block
// Assumes: zero wait AHB-Lite slave, short period to keep runs brief
// Notes:   drive levels sampled at the falling edge where they are settled
`timescale 1ns/10ps
module peak_current_bridge_pwm_tb_top;
   import bridge_pkg::*;
   localparam logic [15:0] PER = 16'h0028;
   localparam logic [15:0] DBA = 16'h0003;
   localparam logic [15:0] DBP = 16'h0002;
   localparam logic [15:0] DBL = 16'h0006;
   logic             mclk = 1'b0;
   logic             rst = 1'b1;
   logic             hsel = 1'b0;
   logic [31:0]      haddr = 32'h0;
   logic [1:0]       htrans = 2'b00;
   logic             hwrite = 1'b0;
   logic [31:0]      hwdata = 32'h0;
   logic             cmp = 1'b0;
   logic             hreadyout;
   logic             hresp;
   logic             shoot;
   logic [31:0]      hrdata;
   drive_t           drive;
   logic [DAC_W-1:0] dac;
   int               bad_count = 0;
   int               num_checks = 0;
   int               cycles = 0;

   always #5 mclk = ~mclk;

   peak_current_bridge_pwm dut (
      .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cmp_trip_async(cmp), .drive(drive),
      .dac_code(dac));

   gate_driver_model drv (.mclk(mclk), .rst(rst), .drive(drive),
      .shoot_ff(shoot));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a hang anywhere ends here; normal run is under two thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   // entered just after a rising edge; holds each phase until hready
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic t_reset;
      logic [31:0] rd;
      check(drive, 6'h00);
      check(dac, 12'h000);
      check(hresp, 1'b0);
      bus(1'b0, OFS_PERIOD, 32'h0, rd);
      check(rd[15:0], RST_PERIOD);
      wr(8'h20, 32'hffff_ffff);
      bus(1'b0, 8'h20, 32'h0, rd);
      check(rd, 32'h0);
   endtask

   task automatic t_passive;
      int ha;
      int hb;
      ha = 0;
      hb = 0;
      @(posedge drive.passive_leg_out_a);
      for (int i = 0; i < 2 * PER; i++) begin
         @(negedge mclk);
         ha += drive.passive_leg_out_a;
         hb += drive.passive_leg_out_b;
         if (i == 2 * PER - 1) check(drive.passive_leg_out_a, 1'b0);
      end
      @(negedge mclk);
      check(drive.passive_leg_out_a, 1'b1);
      check(ha, PER - DBP);
      check(hb, PER - DBP);
   endtask

   task automatic t_ramp;
      logic [DAC_W-1:0] d0;
      logic [31:0]      rd;
      @(negedge mclk);
      check(dac, 12'h800);
      @(posedge mclk);
      wr(OFS_RAMP_SLOPE, 32'h10);
      @(posedge drive.passive_leg_out_a);
      @(negedge mclk);
      d0 = dac;
      repeat (10) @(negedge mclk);
      // one count per clock at the lowest dac step
      check(d0 - dac, 32'd10);
      @(posedge drive.passive_leg_out_b);
      @(negedge mclk);
      check(dac, d0);
      // three decrements after the reload at period
      @(posedge mclk);
      bus(1'b0, OFS_RAMP_VALUE, 32'h0, rd);
      check(rd, {16'h0, 16'h8000 - 16'h0030});
   endtask

   task automatic trip_half(input logic up, input logic [15:0] db);
      logic [31:0] rd;
      int n;
      repeat (8) @(posedge mclk);
      check(up ? drive.active_leg_out_b : drive.active_leg_out_a, 1'b1);
      cmp <= 1'b1;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while ((up ? drive.active_leg_out_b : drive.active_leg_out_a)
                 === 1'b1 && n < 9);
      check(n <= 4, 1'b1);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while ((up ? drive.active_leg_out_a : drive.active_leg_out_b)
                 !== 1'b1 && n < 20);
      check(n, db);
      @(posedge mclk);
      cmp <= 1'b0;
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      check(rd[STS_TRIP_BIT], 1'b1);
   endtask

   task automatic t_trip;
      logic [31:0] rd;
      @(posedge drive.passive_leg_out_a);
      trip_half(1'b1, DBA);
      @(posedge drive.passive_leg_out_b);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      check(rd[STS_TRIP_BIT], 1'b0);
      check(rd[STS_DIR_BIT], 1'b0);
      trip_half(1'b0, DBA);
      @(posedge drive.passive_leg_out_a);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      check(rd[STS_TRIP_BIT], 1'b0);
   endtask

   // lighter load: software lengthens the active deadtime
   task automatic t_light;
      wr(OFS_DB_ACTIVE, {16'h0, DBL});
      @(posedge drive.passive_leg_out_a);
      trip_half(1'b1, DBL);
   endtask

   function automatic logic [1:0] rect_exp(input logic [1:0] m,
                                           input drive_t d);
      logic d1;
      logic d2;
      d1 = d.passive_leg_out_a & d.active_leg_out_b;
      d2 = d.passive_leg_out_b & d.active_leg_out_a;
      case (m)
         2'd1: rect_exp = {d1, d2};
         2'd2: rect_exp = {~d2, ~d1};
         default: rect_exp = 2'b00;
      endcase
   endfunction

   task automatic t_modes;
      logic [31:0] rd;
      for (int m = 0; m < 4; m++) begin
         wr(OFS_CTRL, {29'h0, m[1:0], 1'b1});
         @(posedge drive.passive_leg_out_a);
         for (int i = 0; i < 2 * PER; i++) begin
            @(negedge mclk);
            check({drive.rectifier_out_a, drive.rectifier_out_b},
                  rect_exp(m[1:0], drive));
         end
         @(posedge mclk);
         bus(1'b0, OFS_STATUS, 32'h0, rd);
         check(rd[STS_MODE_LSB +: 2], m[1:0]);
      end
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      wr(OFS_PERIOD, {16'h0, PER});
      wr(OFS_DB_ACTIVE, {16'h0, DBA});
      wr(OFS_DB_PASSIVE, {16'h0, DBP});
      wr(OFS_RAMP_START, 32'h8000);
      wr(OFS_CTRL, 32'h3);
      t_passive();
      t_ramp();
      t_trip();
      t_light();
      t_modes();
      wr(OFS_CTRL, 32'h0);
      repeat (4) @(negedge mclk);
      check(drive, 6'h00);
      check(shoot, 1'b0);
      summarize();
   end
endmodule
